// [core/shear_cmd_pkg.sv]
// shared constants and types for the shear axis command-input block
package shear_cmd_pkg;
    localparam int CNT_W = 16;
    localparam int POS_W = 24;
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [23:0] POS_RST = 24'h000000;
    localparam logic [1:0] SAW_OFF = 2'h0;
    localparam logic [1:0] SAW_AUTO = 2'h1;
    localparam logic [1:0] SAW_EXT = 2'h2;
    // motion commands to an axis drive
    localparam logic [1:0] MV_HOLD = 2'h0;
    localparam logic [1:0] MV_FWD = 2'h1;
    localparam logic [1:0] MV_REV = 2'h2;

    typedef enum logic [2:0]
    {
        H_IDLE    = 3'h0,
        H_SAW_REV = 3'h1,
        H_SAW_FWD = 3'h3,
        H_CAR_REV = 3'h2,
        H_CAR_FWD = 3'h6,
        H_DONE    = 3'h7
    } home_state_t;

    typedef enum logic [1:0]
    {
        S_IDLE = 2'h0,
        S_CUT  = 2'h1,
        S_RET  = 2'h3
    } saw_state_t;
endpackage

// [core/edge_rise.sv]
// rising-edge detector for a one-shot command input
module edge_rise
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic ce,
    input  wire logic level,
    output logic      pulse
);
    logic level_reg;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            level_reg <= 1'b0;
        else if (ce)
            level_reg <= level;
    end

    // gated by ce so a frozen cycle cannot fire a command
    assign pulse = ce & level & ~level_reg;
endmodule

// [core/batch_counters.sv]
// batch and waste counters with decrement and clear commands
module batch_counters
(
    input  wire logic                           clk,
    input  wire logic                           rst,
    input  wire logic                           ce,
    input  wire logic                           piece_cut,
    input  wire logic                           decr,
    input  wire logic                           clr,
    output logic [shear_cmd_pkg::CNT_W-1:0]     batch_reg,
    output logic [shear_cmd_pkg::CNT_W-1:0]     waste_reg
);
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            batch_reg <= shear_cmd_pkg::CNT_RST;
            waste_reg <= shear_cmd_pkg::CNT_RST;
        end
        else if (ce)
        begin
            if (clr)
            begin
                batch_reg <= shear_cmd_pkg::CNT_RST;
                waste_reg <= shear_cmd_pkg::CNT_RST;
            end
            else if (decr)
            begin
                // a cut in the same cycle cancels the decrement on the batch count
                batch_reg <= piece_cut ? batch_reg : batch_reg - 1'b1;
                waste_reg <= waste_reg + 1'b1;
            end
            else if (piece_cut)
                batch_reg <= batch_reg + 1'b1;
        end
    end

    property p_clr;
        @(posedge clk) disable iff (rst)
        ce && clr |=> batch_reg == '0 && waste_reg == '0;
    endproperty
    a_clr: assert property (p_clr) else $error("batch clear did not zero counters");
    property p_waste;
        @(posedge clk) disable iff (rst)
        ce && decr && !clr |=> waste_reg == $past(waste_reg) + 1'b1;
    endproperty
    a_waste: assert property (p_waste) else $error("decrement did not raise waste count");
    property p_decr;
        @(posedge clk) disable iff (rst)
        ce && decr && !clr && !piece_cut |=>
            batch_reg == $past(batch_reg) - 1'b1 && waste_reg == $past(waste_reg) + 1'b1;
    endproperty
    a_decr: assert property (p_decr) else $error("decrement did not move both counters");
endmodule

// [core/shear_axis_command_inputs.sv]
// command-input handling for the carriage and saw axes of a flying shear
module shear_axis_command_inputs
(
    input  wire logic                              clk,
    input  wire logic                              rst,
    input  wire logic                              ce,
    input  wire logic                              run,
    input  wire logic                              material_moving,
    input  wire logic [1:0]                        saw_mode,
    input  wire logic                              loop_bypass,
    input  wire logic                              alt_sync_mode,
    input  wire logic                              return_inhibit,
    input  wire logic                              decel_done,
    input  wire logic                              carriage_synced,
    input  wire logic                              piece_cut,
    input  wire logic                              batch_decr,
    input  wire logic                              batch_clear,
    input  wire logic                              saw_start,
    input  wire logic                              saw_return,
    input  wire logic                              saw_jog_fwd,
    input  wire logic                              saw_jog_rev,
    input  wire logic                              homing_cmd,
    input  wire logic                              carriage_at_home,
    input  wire logic                              saw_at_home,
    input  wire logic                              saw_cut_end,
    input  wire logic                              saw_ref,
    input  wire logic                              carriage_ref,
    input  wire logic [shear_cmd_pkg::POS_W-1:0]   saw_pos,
    output logic                                   carriage_loop_en_reg,
    output logic                                   carriage_err_clr_reg,
    output logic                                   alt_sync_reg,
    output logic                                   carriage_hold_reg,
    output logic [1:0]                             saw_move_reg,
    output logic [1:0]                             carriage_home_move_reg,
    output logic                                   saw_loop_en_reg,
    output logic [shear_cmd_pkg::POS_W-1:0]        saw_home_pos_reg,
    output logic                                   saw_cycle_reg,
    output logic                                   homing_busy_reg,
    output logic                                   homing_done_reg,
    output logic [shear_cmd_pkg::CNT_W-1:0]        batch_count,
    output logic [shear_cmd_pkg::CNT_W-1:0]        waste_count
);
    logic        decr_p;
    logic        clr_p;
    logic        start_p;
    logic        ret_p;
    logic        home_p;
    logic        sync_p;
    logic        saw_used;
    logic        jog_active;
    logic        jog_prev_reg;
    logic        start_ok;
    shear_cmd_pkg::home_state_t home_state_reg;
    shear_cmd_pkg::home_state_t home_next;
    shear_cmd_pkg::saw_state_t  saw_state_reg;

    edge_rise u_decr (.clk(clk), .rst(rst), .ce(ce), .level(batch_decr), .pulse(decr_p));
    edge_rise u_clr (.clk(clk), .rst(rst), .ce(ce), .level(batch_clear), .pulse(clr_p));
    edge_rise u_start (.clk(clk), .rst(rst), .ce(ce), .level(saw_start), .pulse(start_p));
    edge_rise u_ret (.clk(clk), .rst(rst), .ce(ce), .level(saw_return), .pulse(ret_p));
    edge_rise u_home (.clk(clk), .rst(rst), .ce(ce), .level(homing_cmd), .pulse(home_p));
    // internal start in mode 1 fires once when the carriage reaches sync
    edge_rise u_sync (.clk(clk), .rst(rst), .ce(ce), .level(carriage_synced), .pulse(sync_p));

    batch_counters u_cnt (.clk(clk), .rst(rst), .ce(ce), .piece_cut(piece_cut),
        .decr(decr_p), .clr(clr_p),
        .batch_reg(batch_count), .waste_reg(waste_count));

    assign saw_used = (saw_mode == shear_cmd_pkg::SAW_AUTO) || (saw_mode == shear_cmd_pkg::SAW_EXT);
    // saw jog only while stopped and no homing or cut in progress
    assign jog_active = !run && (saw_jog_fwd ^ saw_jog_rev)
                        && !homing_busy_reg
                        && saw_state_reg == shear_cmd_pkg::S_IDLE;
    // external start: at standstill needs stop and home; in mode 2 it follows sync
    always_comb
    begin
        start_ok = 1'b0;
        // a finished homing leaves the sequencer in its done state, which must not block starts
        if (saw_used && saw_state_reg == shear_cmd_pkg::S_IDLE && !homing_busy_reg)
        begin
            if (saw_mode == shear_cmd_pkg::SAW_AUTO && material_moving)
                start_ok = sync_p;
            else if (!material_moving)
                start_ok = start_p && !run && carriage_at_home;
            else
                start_ok = start_p && carriage_synced;
        end
    end

    // carriage loop control
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            carriage_loop_en_reg <= 1'b1;
            carriage_err_clr_reg <= 1'b0;
            alt_sync_reg         <= 1'b0;
        end
        else if (ce)
        begin
            carriage_loop_en_reg <= !loop_bypass;
            carriage_err_clr_reg <= loop_bypass;
            alt_sync_reg         <= alt_sync_mode;
        end
    end

    // return inhibit: hold after forward deceleration while the command stands
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            carriage_hold_reg <= 1'b0;
        else if (ce)
            carriage_hold_reg <= return_inhibit && (decel_done || carriage_hold_reg);
    end

    // saw cutting cycle
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            saw_state_reg <= shear_cmd_pkg::S_IDLE;
            saw_cycle_reg <= 1'b0;
        end
        else if (ce)
        begin
            case (saw_state_reg)
                shear_cmd_pkg::S_IDLE:
                begin
                    if (start_ok)
                    begin
                        saw_state_reg <= shear_cmd_pkg::S_CUT;
                        saw_cycle_reg <= 1'b1;
                    end
                end
                shear_cmd_pkg::S_CUT:
                begin
                    // an abort and a normal cut end both send the saw to return the same way
                    if (ret_p || saw_cut_end)
                    begin
                        saw_state_reg <= shear_cmd_pkg::S_RET;
                        saw_cycle_reg <= 1'b0;
                    end
                end
                shear_cmd_pkg::S_RET:
                begin
                    if (saw_at_home)
                        saw_state_reg <= shear_cmd_pkg::S_IDLE;
                end
                default:
                begin
                    saw_state_reg <= shear_cmd_pkg::S_IDLE;
                    saw_cycle_reg <= 1'b0;
                end
            endcase
        end
    end

    // homing sequence
    always_comb
    begin
        home_next = home_state_reg;
        case (home_state_reg)
            shear_cmd_pkg::H_IDLE, shear_cmd_pkg::H_DONE:
            begin
                if (home_p && !run && carriage_at_home)
                    home_next = saw_used ? shear_cmd_pkg::H_SAW_REV
                                         : shear_cmd_pkg::H_CAR_REV;
            end
            shear_cmd_pkg::H_SAW_REV:
                if (saw_ref)
                    home_next = shear_cmd_pkg::H_SAW_FWD;
            shear_cmd_pkg::H_SAW_FWD:
                if (saw_at_home)
                    home_next = shear_cmd_pkg::H_CAR_REV;
            shear_cmd_pkg::H_CAR_REV:
                if (carriage_ref)
                    home_next = shear_cmd_pkg::H_CAR_FWD;
            shear_cmd_pkg::H_CAR_FWD:
                if (carriage_at_home)
                    home_next = shear_cmd_pkg::H_DONE;
            default:
                home_next = shear_cmd_pkg::H_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            home_state_reg         <= shear_cmd_pkg::H_IDLE;
            homing_busy_reg        <= 1'b0;
            homing_done_reg        <= 1'b0;
            carriage_home_move_reg <= shear_cmd_pkg::MV_HOLD;
        end
        else if (ce)
        begin
            home_state_reg  <= home_next;
            homing_busy_reg <= home_next != shear_cmd_pkg::H_IDLE
                               && home_next != shear_cmd_pkg::H_DONE;
            homing_done_reg <= home_next == shear_cmd_pkg::H_DONE;
            // carriage stays stopped during saw homing
            case (home_next)
                shear_cmd_pkg::H_CAR_REV:
                    carriage_home_move_reg <= shear_cmd_pkg::MV_REV;
                shear_cmd_pkg::H_CAR_FWD:
                    carriage_home_move_reg <= shear_cmd_pkg::MV_FWD;
                default:
                    carriage_home_move_reg <= shear_cmd_pkg::MV_HOLD;
            endcase
        end
    end

    // saw drive command: homing, return, cut, jog, else hold
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            saw_move_reg    <= shear_cmd_pkg::MV_HOLD;
            saw_loop_en_reg <= 1'b1;
        end
        else if (ce)
        begin
            saw_loop_en_reg <= 1'b1;
            if (home_next == shear_cmd_pkg::H_SAW_REV)
                saw_move_reg <= shear_cmd_pkg::MV_REV;
            else if (home_next == shear_cmd_pkg::H_SAW_FWD)
                saw_move_reg <= shear_cmd_pkg::MV_FWD;
            else if (saw_state_reg == shear_cmd_pkg::S_RET)
                saw_move_reg <= saw_at_home ? shear_cmd_pkg::MV_HOLD
                                            : shear_cmd_pkg::MV_REV;
            else if (saw_state_reg == shear_cmd_pkg::S_CUT)
                saw_move_reg <= shear_cmd_pkg::MV_FWD;
            else if (jog_active)
                saw_move_reg <= saw_jog_fwd ? shear_cmd_pkg::MV_FWD
                                            : shear_cmd_pkg::MV_REV;
            else
                saw_move_reg <= shear_cmd_pkg::MV_HOLD;
        end
    end

    // the position where a jog ends becomes the saw's new home
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            jog_prev_reg     <= 1'b0;
            saw_home_pos_reg <= shear_cmd_pkg::POS_RST;
        end
        else if (ce)
        begin
            jog_prev_reg <= jog_active;
            if (jog_prev_reg && !jog_active)
                saw_home_pos_reg <= saw_pos;
        end
    end

    property p_bypass;
        @(posedge clk) disable iff (rst)
        ce && loop_bypass |=> carriage_err_clr_reg && !carriage_loop_en_reg;
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass did not open loop");
    property p_loop;
        @(posedge clk) disable iff (rst)
        ce && !loop_bypass |=> carriage_loop_en_reg && !carriage_err_clr_reg;
    endproperty
    a_loop: assert property (p_loop) else $error("loop not closed");
    property p_jog_stop;
        @(posedge clk) disable iff (rst)
        ce && run && home_next inside {shear_cmd_pkg::H_IDLE, shear_cmd_pkg::H_DONE}
        && saw_state_reg == shear_cmd_pkg::S_IDLE |=> saw_move_reg == shear_cmd_pkg::MV_HOLD;
    endproperty
    a_jog_stop: assert property (p_jog_stop) else $error("saw moved while running");
    property p_jog;
        @(posedge clk) disable iff (rst)
        ce && jog_active && saw_jog_fwd
        && home_next inside {shear_cmd_pkg::H_IDLE, shear_cmd_pkg::H_DONE}
        |=> saw_move_reg == shear_cmd_pkg::MV_FWD;
    endproperty
    a_jog: assert property (p_jog) else $error("saw jog forward not driven");
    property p_home_gate;
        @(posedge clk) disable iff (rst)
        ce && home_state_reg == shear_cmd_pkg::H_IDLE && (run || !carriage_at_home)
        |=> home_state_reg == shear_cmd_pkg::H_IDLE;
    endproperty
    a_home_gate: assert property (p_home_gate) else $error("homing accepted illegally");
    property p_home_saw;
        @(posedge clk) disable iff (rst)
        home_state_reg == shear_cmd_pkg::H_SAW_REV
        |-> carriage_home_move_reg == shear_cmd_pkg::MV_HOLD;
    endproperty
    a_home_saw: assert property (p_home_saw) else $error("carriage moved in saw homing");
    property p_done;
        @(posedge clk) disable iff (rst)
        ce && home_state_reg == shear_cmd_pkg::H_CAR_FWD && carriage_at_home
        |=> homing_done_reg;
    endproperty
    a_done: assert property (p_done) else $error("homing done not set");
    property p_inhibit;
        @(posedge clk) disable iff (rst)
        ce && !return_inhibit |=> !carriage_hold_reg;
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("hold outlived inhibit");
    property p_ret;
        @(posedge clk) disable iff (rst)
        ce && saw_state_reg == shear_cmd_pkg::S_CUT && ret_p
        |=> saw_state_reg == shear_cmd_pkg::S_RET && !saw_cycle_reg;
    endproperty
    a_ret: assert property (p_ret) else $error("saw return ignored");
    property p_once;
        @(posedge clk) disable iff (rst)
        start_p |=> !start_p;
    endproperty
    a_once: assert property (p_once) else $error("start pulse repeated");

    c_cut: cover property (@(posedge clk) disable iff (rst) saw_state_reg == shear_cmd_pkg::S_CUT);
    c_home: cover property (@(posedge clk) disable iff (rst) homing_done_reg);
    c_jog: cover property (@(posedge clk) disable iff (rst) jog_prev_reg && !jog_active);
    c_hold: cover property (@(posedge clk) disable iff (rst) carriage_hold_reg);
endmodule

// [testbench/shear_axis_drives_model.sv]
// behavioural carriage and saw drives with reference and home feedback
module shear_axis_drives_model
#(
    parameter int HOME    = 8,
    parameter int CUT_END = 16
)
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [1:0]  saw_move,
    input  wire logic [1:0]  car_move,
    output logic             saw_at_home,
    output logic             saw_ref,
    output logic             saw_cut_end,
    output logic             carriage_at_home,
    output logic             carriage_ref,
    output logic [23:0]      saw_pos
);
    timeunit 1ns;
    timeprecision 100ps;
    int saw_p;
    int car_p;
    int saw_next;
    int car_next;

    // feedback shows the position reached at the coming edge, so a registered stop lands on it
    assign saw_next = (saw_move == shear_cmd_pkg::MV_FWD) ? saw_p + 1
                    : (saw_move == shear_cmd_pkg::MV_REV) ? saw_p - 1 : saw_p;
    assign car_next = (car_move == shear_cmd_pkg::MV_FWD) ? car_p + 1
                    : (car_move == shear_cmd_pkg::MV_REV) ? car_p - 1 : car_p;

    // one position step per cycle, so every arrival at ref, cut end or home lands a few cycles after a move
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            saw_p <= HOME;
            car_p <= HOME;
        end
        else
        begin
            saw_p <= saw_next;
            car_p <= car_next;
        end
    end

    assign saw_at_home      = (saw_next == HOME);
    assign saw_ref          = (saw_next <= 0);
    assign saw_cut_end      = (saw_next >= CUT_END);
    assign carriage_at_home = (car_next == HOME);
    assign carriage_ref     = (car_next <= 0);
    assign saw_pos          = saw_next[23:0];
endmodule

// [testbench/shear_axis_command_inputs_test.sv]
// self-checking bench for the shear axis command-input block
module shear_axis_command_inputs_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 0, rst = 1, run = 0, mat = 0, bypass = 0, alt = 0, inhibit = 0, decel = 0;
    logic synced = 0, piece = 0, decr = 0, clr = 0, start = 0, ret = 0, jf = 0, jr = 0, home = 0;
    logic [1:0] mode = 2'h0;
    logic sah, sref, send, cah, cref, loop_en, err_clr, alt_q, hold, cyc, busy, done, saw_le;
    logic [1:0] saw_mv, car_mv;
    logic [23:0] spos, shome;
    logic [15:0] batch, waste;
    int error_cnt = 0, comparisons = 0, cycles = 0, i;
    logic [23:0] jog_pos;

    always #5 clk = ~clk;

    shear_axis_command_inputs DUT
    (
        .clk(clk), .rst(rst), .ce(1'b1), .run(run), .material_moving(mat), .saw_mode(mode),
        .loop_bypass(bypass), .alt_sync_mode(alt), .return_inhibit(inhibit),
        .decel_done(decel), .carriage_synced(synced), .piece_cut(piece), .batch_decr(decr),
        .batch_clear(clr), .saw_start(start), .saw_return(ret), .saw_jog_fwd(jf),
        .saw_jog_rev(jr), .homing_cmd(home), .carriage_at_home(cah), .saw_at_home(sah),
        .saw_cut_end(send), .saw_ref(sref), .carriage_ref(cref), .saw_pos(spos),
        .carriage_loop_en_reg(loop_en), .carriage_err_clr_reg(err_clr), .alt_sync_reg(alt_q),
        .carriage_hold_reg(hold), .saw_move_reg(saw_mv), .carriage_home_move_reg(car_mv),
        .saw_loop_en_reg(saw_le), .saw_home_pos_reg(shome), .saw_cycle_reg(cyc),
        .homing_busy_reg(busy), .homing_done_reg(done), .batch_count(batch), .waste_count(waste)
    );

    shear_axis_drives_model drives
    (
        .clk(clk), .rst(rst), .saw_move(saw_mv), .car_move(car_mv), .saw_at_home(sah),
        .saw_ref(sref), .saw_cut_end(send), .carriage_at_home(cah), .carriage_ref(cref),
        .saw_pos(spos)
    );

    task automatic chk(input string name, input logic [23:0] seen, input logic [23:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask

    // inputs change by nba on a rising edge; a check reads what stood just before a later edge
    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic look(input int n);
        step(n);
        @(negedge clk);
        @(posedge clk);
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // the whole sequence needs well under 1000 cycles
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            error_cnt++;
            close_out();
        end
    end

    initial
    begin
        step(10);
        rst <= 0;
        look(1);
        chk("loop_en", {23'h0, loop_en}, 24'h1);
        chk("batch", {8'h0, batch}, 24'h0);
        bypass <= 1;
        look(2);
        chk("loop_en", {23'h0, loop_en}, 24'h0);
        chk("err_clr", {23'h0, err_clr}, 24'h1);
        bypass <= 0;
        look(2);
        chk("loop_en", {23'h0, loop_en}, 24'h1);
        chk("err_clr", {23'h0, err_clr}, 24'h0);
        for (i = 0; i < 3; i++)
        begin
            piece <= 1;
            step(1);
            piece <= 0;
            step(1);
        end
        decr <= 1;
        look(4);
        chk("batch", {8'h0, batch}, 24'h2);
        chk("waste", {8'h0, waste}, 24'h1);
        decr <= 0;
        clr <= 1;
        look(3);
        chk("batch", {8'h0, batch}, 24'h0);
        chk("waste", {8'h0, waste}, 24'h0);
        clr <= 0;
        alt <= 1;
        look(2);
        chk("alt_sync", {23'h0, alt_q}, 24'h1);
        alt <= 0;
        // homing refused while running, then accepted in stop state with the saw in use
        mode <= shear_cmd_pkg::SAW_AUTO;
        run <= 1;
        home <= 1;
        look(2);
        chk("busy", {23'h0, busy}, 24'h0);
        home <= 0;
        run <= 0;
        step(2);
        home <= 1;
        look(1);
        chk("busy", {23'h0, busy}, 24'h1);
        chk("saw_move", {22'h0, saw_mv}, 24'h2);
        chk("car_move", {22'h0, car_mv}, 24'h0);
        home <= 0;
        for (i = 0; i < 200 && done !== 1'b1; i++)
            step(1);
        chk("done", {23'h0, done}, 24'h1);
        chk("busy", {23'h0, busy}, 24'h0);
        // saw start refused while running, accepted in stop state, aborted by saw return
        run <= 1;
        start <= 1;
        look(2);
        chk("cycle", {23'h0, cyc}, 24'h0);
        start <= 0;
        run <= 0;
        step(2);
        start <= 1;
        look(2);
        chk("cycle", {23'h0, cyc}, 24'h1);
        chk("saw_move", {22'h0, saw_mv}, 24'h1);
        ret <= 1;
        look(2);
        chk("saw_move", {22'h0, saw_mv}, 24'h2);
        start <= 0;
        ret <= 0;
        // wait until the saw is back and holding, not only until the cut flag drops
        for (i = 0; i < 100 && saw_mv !== 2'h0; i++)
            step(1);
        chk("cycle", {23'h0, cyc}, 24'h0);
        chk("saw_home", {23'h0, sah}, 24'h1);
        // internal start on carriage sync in mode 1
        run <= 1;
        mat <= 1;
        synced <= 1;
        look(3);
        chk("cycle", {23'h0, cyc}, 24'h1);
        for (i = 0; i < 100 && saw_mv !== 2'h0; i++)
            step(1);
        chk("cycle", {23'h0, cyc}, 24'h0);
        mode <= shear_cmd_pkg::SAW_EXT;
        step(2);
        start <= 1;
        look(2);
        chk("cycle", {23'h0, cyc}, 24'h1);
        start <= 0;
        for (i = 0; i < 100 && saw_mv !== 2'h0; i++)
            step(1);
        synced <= 0;
        mat <= 0;
        // jog ignored while running, obeyed in stop state
        jf <= 1;
        look(2);
        chk("saw_move", {22'h0, saw_mv}, 24'h0);
        run <= 0;
        look(3);
        chk("saw_move", {22'h0, saw_mv}, 24'h1);
        jf <= 0;
        look(3);
        jog_pos = spos;
        chk("saw_move", {22'h0, saw_mv}, 24'h0);
        chk("saw_home_pos", shome, jog_pos);
        chk("saw_loop", {23'h0, saw_le}, 24'h1);
        jr <= 1;
        look(2);
        chk("saw_move", {22'h0, saw_mv}, 24'h2);
        jr <= 0;
        // return inhibit holds the carriage after the forward ramp until released
        inhibit <= 1;
        decel <= 1;
        look(2);
        chk("hold", {23'h0, hold}, 24'h1);
        decel <= 0;
        look(2);
        chk("hold", {23'h0, hold}, 24'h1);
        inhibit <= 0;
        look(2);
        chk("hold", {23'h0, hold}, 24'h0);
        close_out();
    end
endmodule
